/* include/usb_sts_pkg.sv */
// Constants for the host controller status register block.
// Assumes byte addressing of the operational register window.
package usb_sts_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] STS_OFFSET = 8'h24;
  // Field positions
  localparam int ASYNC_STATE_POS = 15;
  localparam int PERIODIC_STATE_POS = 14;
  localparam int RECLAIM_POS = 13;
  localparam int HALTED_POS = 12;
  localparam int ADVANCE_POS = 5;
  localparam int SYS_ERR_POS = 4;
  localparam int ROLLOVER_POS = 3;
  localparam int PORT_CHG_POS = 2;
  localparam int TXN_ERR_POS = 1;
  localparam int TXN_DONE_POS = 0;
  localparam int FLAG_COUNT = 6;
  // Reset values
  localparam logic HALTED_RESET = 1'b1;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic STATE_RESET = 1'b0;
  // Frame list size selections and the index bit that wraps for each
  localparam logic [1:0] FLS_1024 = 2'h0;
  localparam logic [1:0] FLS_512 = 2'h1;
  localparam logic [1:0] FLS_256 = 2'h2;
  localparam int WRAP_BIT_1024 = 13;
  localparam int WRAP_BIT_512 = 12;
  localparam int WRAP_BIT_256 = 11;
  localparam int FRAME_INDEX_W = 14;
endpackage

/* rtl/sticky_flag.sv */
// One write-one-to-clear status flag.
// Assumes set and clear are single-cycle strobes in the clk domain.
`timescale 1ns/10ps
module sticky_flag
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic setPulse,
  input wire logic clearPulse,
  output logic flag
);
  import usb_sts_pkg::*;

  typedef struct packed
  {
    logic flag;
  } flag_state_t;

  flag_state_t st_ff;
  flag_state_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    // Set wins so an event in the clearing cycle is not lost
    if (setPulse)
    begin
      nxt_st.flag = 1'b1;
    end
    else if (clearPulse)
    begin
      nxt_st.flag = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff <= '{flag: FLAG_RESET};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign flag = st_ff.flag;
endmodule

/* rtl/usb_host_status_register.sv */
// Status register of a high-speed USB host controller.
// Assumes the command register, frame index counter, scheduler and
// port registers sit outside and present their state on plain ports.
`timescale 1ns/10ps
module usb_host_status_register
#(
  parameter int PORTS = 4
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [usb_sts_pkg::ADDR_W-1:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  input wire logic runStop,
  input wire logic pipelineIdle,
  input wire logic asyncSchedEnable,
  input wire logic periodicSchedEnable,
  input wire logic microframeTick,
  input wire logic emptyAsyncDetect,
  input wire logic doorbellWrite,
  input wire logic asyncAdvanced,
  input wire logic hostSysError,
  input wire logic [1:0] frameListSizeSel,
  input wire logic [usb_sts_pkg::FRAME_INDEX_W-1:0] frameIndex,
  input wire logic [PORTS-1:0] portChange,
  input wire logic [PORTS-1:0] companionOwned,
  input wire logic [PORTS-1:0] forceResume,
  input wire logic [PORTS-1:0] suspendedJk,
  input wire logic powerWake,
  input wire logic txnError,
  input wire logic txnRetire,
  input wire logic retireIoc,
  input wire logic shortPacket,
  output logic runStopClear,
  output logic advanceAck
);
  import usb_sts_pkg::*;

  // Refused while elaborating, so a bad width never reaches a netlist
  if (PORTS < 1 || PORTS > 15)
  begin : g_ports_check
    $error("PORTS out of range");
  end

  typedef struct packed
  {
    logic [31:0] rdata;
    logic asyncState;
    logic periodicState;
    logic reclaim;
    logic halted;
    logic doorbellArmed;
    logic prevWrapBit;
    logic [PORTS-1:0] prevChange;
    logic [PORTS-1:0] prevResume;
    logic runStopClear;
    logic advanceAck;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic [FLAG_COUNT-1:0] flagSet;
  logic [FLAG_COUNT-1:0] flagClr;
  logic [FLAG_COUNT-1:0] flags;
  logic stsHit;
  logic wrapBit;
  logic portEvent;
  logic [31:0] readValue;

  assign stsHit = (regAddr == STS_OFFSET);

  always_comb
  begin
    case (frameListSizeSel)
      FLS_1024: wrapBit = frameIndex[WRAP_BIT_1024];
      FLS_512: wrapBit = frameIndex[WRAP_BIT_512];
      FLS_256: wrapBit = frameIndex[WRAP_BIT_256];
      default: wrapBit = frameIndex[WRAP_BIT_1024];
    endcase
  end

  assign portEvent = |((portChange & ~st_ff.prevChange & ~companionOwned)
    | (forceResume & ~st_ff.prevResume & suspendedJk));

  always_comb
  begin
    flagSet = '0;
    flagSet[ADVANCE_POS] = st_ff.doorbellArmed & asyncAdvanced;
    flagSet[SYS_ERR_POS] = hostSysError;
    flagSet[ROLLOVER_POS] = wrapBit ^ st_ff.prevWrapBit;
    flagSet[PORT_CHG_POS] = portEvent | (powerWake & |portChange);
    flagSet[TXN_ERR_POS] = txnError;
    flagSet[TXN_DONE_POS] = (txnRetire & retireIoc) | (txnError & retireIoc)
      | shortPacket;
    // Only flag positions clear; other write bits are dropped
    flagClr = (regWr && stsHit) ? regWdata[FLAG_COUNT-1:0] : '0;
  end

  genvar gi;
  generate
    for (gi = 0; gi < FLAG_COUNT; gi++)
    begin : g_flag
      sticky_flag u_flag
      (
        .clk(clk),
        .reset_n(reset_n),
        .setPulse(flagSet[gi]),
        .clearPulse(flagClr[gi]),
        .flag(flags[gi])
      );
    end
  endgenerate

  always_comb
  begin
    readValue = '0;
    readValue[ASYNC_STATE_POS] = st_ff.asyncState;
    readValue[PERIODIC_STATE_POS] = st_ff.periodicState;
    readValue[RECLAIM_POS] = st_ff.reclaim;
    // Masked live so a running controller never reads halted
    readValue[HALTED_POS] = st_ff.halted & ~runStop;
    readValue[FLAG_COUNT-1:0] = flags;
  end

  always_comb
  begin
    nxt_st = st_ff;
    // Unmapped reads return zero; reads alter nothing
    nxt_st.rdata = (regRd && stsHit) ? readValue : 32'h0000_0000;
    // Schedule state follows enable only at a microframe boundary
    if (microframeTick)
    begin
      nxt_st.asyncState = asyncSchedEnable;
      nxt_st.periodicState = periodicSchedEnable;
    end
    nxt_st.reclaim = emptyAsyncDetect;
    if (runStop)
    begin
      nxt_st.halted = 1'b0;
    end
    else if (pipelineIdle)
    begin
      nxt_st.halted = 1'b1;
    end
    nxt_st.advanceAck = flagSet[ADVANCE_POS];
    if (doorbellWrite)
    begin
      nxt_st.doorbellArmed = 1'b1;
    end
    else if (flagSet[ADVANCE_POS])
    begin
      nxt_st.doorbellArmed = 1'b0;
    end
    nxt_st.prevWrapBit = wrapBit;
    nxt_st.prevChange = portChange;
    nxt_st.prevResume = forceResume;
    nxt_st.runStopClear = hostSysError;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff <= '{rdata: 32'h0000_0000, asyncState: STATE_RESET,
        periodicState: STATE_RESET, reclaim: STATE_RESET,
        halted: HALTED_RESET, doorbellArmed: 1'b0, prevWrapBit: 1'b0,
        prevChange: '0, prevResume: '0, runStopClear: 1'b0,
        advanceAck: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign regRdata = st_ff.rdata;
  assign runStopClear = st_ff.runStopClear;
  assign advanceAck = st_ff.advanceAck;

  sequence s_wrap;
    $changed(wrapBit) && !$changed(frameListSizeSel);
  endsequence
  sequence s_doorbell_advance;
    doorbellWrite ##1 (asyncAdvanced && !doorbellWrite);
  endsequence

  a_halt_running: assert property (@(posedge clk) disable iff (!reset_n)
    runStop |=> !st_ff.halted)
    else $error("halted set while running");
  a_halt_idle: assert property (@(posedge clk) disable iff (!reset_n)
    (!runStop && pipelineIdle) |=> st_ff.halted)
    else $error("halted not set after stop");
  a_halt_read: assert property (@(posedge clk) disable iff (!reset_n)
    (regRd && stsHit && runStop) |=> !regRdata[HALTED_POS])
    else $error("halted read one while running");
  a_async_follow: assert property (@(posedge clk) disable iff (!reset_n)
    microframeTick |=> st_ff.asyncState == $past(asyncSchedEnable))
    else $error("async state did not follow enable");
  a_periodic_follow: assert property (@(posedge clk) disable iff (!reset_n)
    microframeTick |=> st_ff.periodicState == $past(periodicSchedEnable))
    else $error("periodic state did not follow enable");
  a_doorbell_flag: assert property (@(posedge clk) disable iff (!reset_n)
    s_doorbell_advance |=> flags[ADVANCE_POS] && advanceAck)
    else $error("advance flag missing");
  a_syserr_stop: assert property (@(posedge clk) disable iff (!reset_n)
    hostSysError |=> runStopClear && flags[SYS_ERR_POS])
    else $error("system error did not stop");
  a_rollover_set: assert property (@(posedge clk) disable iff (!reset_n)
    s_wrap |=> flags[ROLLOVER_POS])
    else $error("rollover flag missing");
  a_error_both: assert property (@(posedge clk) disable iff (!reset_n)
    (txnError && retireIoc) |=> flags[TXN_ERR_POS] && flags[TXN_DONE_POS])
    else $error("error with completion not both set");
  a_short_done: assert property (@(posedge clk) disable iff (!reset_n)
    shortPacket |=> flags[TXN_DONE_POS])
    else $error("short packet flag missing");
  a_flag_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    (flags[PORT_CHG_POS] && !(regWr && stsHit && regWdata[PORT_CHG_POS]))
      |=> flags[PORT_CHG_POS])
    else $error("port change flag lost");
  a_clear_flag: assert property (@(posedge clk) disable iff (!reset_n)
    (regWr && stsHit && regWdata[TXN_ERR_POS] && !txnError) |=> !flags[TXN_ERR_POS])
    else $error("error flag not cleared");
endmodule

/* tb/host_sw_model.sv */
// Host software model: reads and clears the status register.
// Assumes the bench calls its tasks once clk runs and reset is over.
`timescale 1ns/10ps
module host_sw_model
(
  input wire logic clk,
  input wire logic [31:0] regRdata,
  output logic [usb_sts_pkg::ADDR_W-1:0] regAddr,
  output logic regWr,
  output logic regRd,
  output logic [31:0] regWdata
);
  import usb_sts_pkg::*;
  initial
  begin
    regAddr = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    regWdata = 32'h00000000;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) #1;
    regAddr = a;
    regWdata = d & 32'h0000F03F;
    regWr = 1'b1;
    @(posedge clk) #1;
    regWr = 1'b0;
    // Released bus must not keep showing the old word
    regWdata = ~regWdata;
    regAddr = ~regAddr;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) #1;
    regAddr = a;
    regRd = 1'b1;
    @(posedge clk) #1;
    regRd = 1'b0;
    regAddr = ~regAddr;
    d = regRdata;
  endtask
endmodule

/* tb/usb_host_status_register_bench.sv */
// Self-checking bench of the status register block.
// Assumes host_sw_model drives the register port.
`timescale 1ns/10ps
module usb_host_status_register_bench;
  import usb_sts_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr;
  logic regWr, regRd;
  logic [31:0] regWdata, regRdata;
  logic runStop = 1'b0, pipelineIdle = 1'b1, emptyAsyncDetect = 1'b0;
  logic asyncSchedEnable = 1'b0, periodicSchedEnable = 1'b0;
  logic [1:0] frameListSizeSel = FLS_1024;
  logic [13:0] frameIndex = 14'h0000;
  logic [3:0] portChange = 4'h0, companionOwned = 4'h0;
  logic [3:0] forceResume = 4'h0, suspendedJk = 4'h0;
  logic [8:0] ev = 9'h000;
  logic runStopClear, advanceAck;
  int fails = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  usb_host_status_register usb_host_status_register_i
  (
    .clk, .reset_n, .regAddr, .regWr, .regRd, .regWdata, .regRdata, .runStop,
    .pipelineIdle, .asyncSchedEnable, .periodicSchedEnable, .microframeTick(ev[8]),
    .emptyAsyncDetect, .doorbellWrite(ev[0]), .asyncAdvanced(ev[1]),
    .hostSysError(ev[2]), .frameListSizeSel, .frameIndex, .portChange,
    .companionOwned, .forceResume, .suspendedJk, .powerWake(ev[7]),
    .txnError(ev[3]), .txnRetire(ev[4]), .retireIoc(ev[5]), .shortPacket(ev[6]),
    .runStopClear, .advanceAck
  );
  host_sw_model host_sw_model_i
  (
    .clk, .regRdata, .regAddr, .regWr, .regRd, .regWdata
  );
  task automatic results;
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [31:0] exp);
    logic [31:0] d;
    host_sw_model_i.rd(STS_OFFSET, d);
    check(d, exp);
  endtask
  task automatic clr;
    host_sw_model_i.wr(STS_OFFSET, 32'h0000003F);
  endtask
  task automatic pulse(input logic [8:0] m);
    @(posedge clk) #1;
    ev = m;
    @(posedge clk) #1;
    ev = 9'h000;
  endtask
  task automatic t_events;
    logic [8:0] evTab [7] = '{9'h002, 9'h004, 9'h008, 9'h028, 9'h030, 9'h010, 9'h040};
    logic [31:0] expTab [7] = '{32'h1000, 32'h1010, 32'h1002, 32'h1003, 32'h1001,
                                32'h1000, 32'h1001};
    for (int i = 0; i < 7; i++)
    begin
      pulse(evTab[i]);
      check({31'h0, runStopClear}, {31'h0, evTab[i] == 9'h004});
      check({31'h0, advanceAck}, 32'h0);
      rdchk(expTab[i]);
      host_sw_model_i.wr(STS_OFFSET, 32'h00000000);
      rdchk(expTab[i]);
      clr();
      rdchk(32'h00001000);
    end
  endtask
  task automatic t_advance;
    pulse(9'h001);
    pulse(9'h002);
    check({31'h0, advanceAck}, 32'h1);
    rdchk(32'h00001020);
    clr();
    // Advance right after the doorbell, with no idle cycle between
    @(posedge clk) #1;
    ev = 9'h001;
    @(posedge clk) #1;
    ev = 9'h002;
    @(posedge clk) #1;
    ev = 9'h000;
    check({31'h0, advanceAck}, 32'h1);
    rdchk(32'h00001020);
    clr();
  endtask
  task automatic t_ports;
    companionOwned = 4'h1;
    portChange = 4'h1;
    rdchk(32'h00001000);
    portChange = 4'h3;
    rdchk(32'h00001004);
    clr();
    suspendedJk = 4'h4;
    forceResume = 4'h4;
    rdchk(32'h00001004);
    clr();
    pulse(9'h080);
    rdchk(32'h00001004);
    clr();
  endtask
  task automatic t_rollover;
    frameIndex = 14'h1FFF;
    rdchk(32'h00001000);
    frameIndex = 14'h2000;
    rdchk(32'h00001008);
    clr();
    frameListSizeSel = FLS_512;
    clr();
    frameIndex = 14'h3000;
    rdchk(32'h00001008);
    clr();
  endtask
  task automatic t_halt;
    runStop = 1'b1;
    rdchk(32'h00000000);
    pipelineIdle = 1'b0;
    runStop = 1'b0;
    rdchk(32'h00000000);
    pipelineIdle = 1'b1;
    rdchk(32'h00001000);
  endtask
  task automatic t_sched;
    logic [31:0] d;
    asyncSchedEnable = 1'b1;
    periodicSchedEnable = 1'b1;
    emptyAsyncDetect = 1'b1;
    rdchk(32'h00003000);
    pulse(9'h100);
    rdchk(32'h0000F000);
    host_sw_model_i.wr(STS_OFFSET, 32'h0000F000);
    rdchk(32'h0000F000);
    host_sw_model_i.rd(8'h20, d);
    check(d, 32'h00000000);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    reset_n = 1'b1;
    rdchk(32'h00001000);
    t_events();
    t_advance();
    t_ports();
    t_rollover();
    t_halt();
    t_sched();
    results();
  end
  // Run needs well under a thousand cycles
  initial
  begin
    #100000;
    fails++;
    results();
  end
endmodule
